// *** core/ptc_pkg.sv ***
// ptc_pkg: register map, field layout, reset values and mode codes of the periodic timer
package ptc_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int CNT_W  = 10;
    localparam int ADDR_W = 6;
    localparam int DIV_W  = 8;

    // ------------------------------------------------------------------
    // register byte offsets (one aligned 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CONTROL      = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS       = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_CMP_A_LOW    = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_CMP_A_HIGH   = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_PERIOD_LOW   = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_PERIOD_HIGH  = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_COUNT_LOW    = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_COUNT_HIGH   = 6'h1C;
    localparam logic [ADDR_W-1:0] OFS_TICK_DIV     = 6'h20;

    // ------------------------------------------------------------------
    // control register field positions
    // ------------------------------------------------------------------
    localparam int CTL_RUN       = 0;
    localparam int CTL_INIT_LVL  = 1;
    localparam int CTL_INVERT    = 2;
    localparam int CTL_CLR_SRC   = 3;
    localparam int CTL_ACT_LO    = 4;
    localparam int CTL_ACT_HI    = 5;
    localparam int CTL_MODE_LO   = 6;
    localparam int CTL_MODE_HI   = 7;
    localparam int CTL_TRIG_FALL = 8;

    // status field positions (write one to clear)
    localparam int STS_MATCH_A = 0;
    localparam int STS_MATCH_P = 1;

    // ------------------------------------------------------------------
    // reset values and fixed counts
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_RESET = 10'h000;
    localparam logic [CNT_W-1:0] CNT_MAX   = 10'h3FF;
    localparam logic [DIV_W-1:0] DIV_RESET = 8'h00;

    // ------------------------------------------------------------------
    // operating modes and output actions
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PTC_MODE_COMPARE = 2'b00,
        PTC_MODE_CAPTURE = 2'b01,
        PTC_MODE_PWM     = 2'b10,
        PTC_MODE_TIMER   = 2'b11
    } ptc_mode_t;

    typedef enum logic [1:0] {
        PTC_ACT_NONE   = 2'b00,
        PTC_ACT_LOW    = 2'b01,
        PTC_ACT_HIGH   = 2'b10,
        PTC_ACT_TOGGLE = 2'b11
    } ptc_action_t;

endpackage : ptc_pkg

// *** core/ptc_prescaler.sv ***
// ptc_prescaler: divides the core clock into the timer count tick
`timescale 1ns/1ps
module ptc_prescaler
    import ptc_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [DIV_W-1:0] div,
    output logic                  tick
);

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             tick;
    } ptc_psc_t;

    ptc_psc_t st;
    ptc_psc_t next_st;

    // one tick every div+1 core clocks; div of zero ticks every clock
    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (st.cnt >= div) begin
            next_st.cnt  = DIV_RESET;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

endmodule : ptc_prescaler

// *** core/ptc_edge_sync.sv ***
// ptc_edge_sync: three-stage synchroniser and edge detector for the trigger pin
`timescale 1ns/1ps
module ptc_edge_sync
    import ptc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic pin,
    input  wire logic fall_sel,
    output logic      edge_pulse
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic pulse;
    } ptc_sync_t;

    ptc_sync_t st;
    ptc_sync_t next_st;

    // a change is accepted only once stages two and three agree
    always_comb begin
        next_st       = st;
        next_st.s1    = pin;
        next_st.s2    = st.s1;
        next_st.s3    = st.s2;
        next_st.pulse = 1'b0;
        if ((st.s2 == st.s3) && (st.s3 != st.level)) begin
            next_st.level = st.s3;
            next_st.pulse = fall_sel ? ~st.s3 : st.s3;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign edge_pulse = st.pulse;

endmodule : ptc_edge_sync

// *** core/ptc_timer.sv ***
// ptc_timer: 10-bit periodic timer with compare, timer, PWM and single pulse modes
//
// Function
// R01: mode bits pick compare, PWM/pulse, timer
// R02: compare, clear-source low: clear on P or overflow
// R03: clear-source high: clear on A, only A flag
// R04: compare A zero: run to 3FF, no A flag
// R05: pin changes only on comparator A flag
// R06: action drives pin high, low, toggle, or none
// R07: run rising edge presets pin to initial level
// R08: timer mode counts like compare, pin not driven
// R09: PWM period from period value, duty from A
// R10: duty at or above period gives full active
// R11: PWM raises both flags, clear-source ignored
// R12: PWM polarity, forced levels, output invert
// R13: PWM counting continues with forced outputs
// R14: software selects single pulse with action 11
// R15: run rise or trigger edge starts the pulse
// R16: pulse ends on run clear or A match
// R17: pulse counter zeroes only on run rise
// R18: compare A split into low byte and two bits
// R19: period split into low byte and two bits
// R20: invert bit flips pin, not in timer mode
// R21: counter readable as low byte and two bits
// R22: counter steps per tick while run is high
// R23: match flags sticky until software clears them
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module ptc_timer
    import ptc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              external_trigger_pin,
    output logic                   timer_out,
    output logic                   timer_out_en
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        ptc_mode_t        mode;
        ptc_action_t      action;
        logic             run_bit;
        logic             out_initial_level;
        logic             out_invert;
        logic             clear_source_sel;
        logic             trig_fall;
        logic             match_a_flag;
        logic             match_p_flag;
        logic [CNT_W-1:0] compare_a_value;
        logic [CNT_W-1:0] period_value;
        logic [CNT_W-1:0] count;
        logic [DIV_W-1:0] tick_div;
        logic             run_prev;
        logic             cmp_level;
        logic             timer_out;
        logic             timer_out_en;
        logic             waitreq;
        logic [31:0]      rdata;
    } ptc_state_t;

    ptc_state_t st;
    ptc_state_t next_st;

    logic       rst_meta;
    logic       rst_n;
    logic       tick;
    logic       trig_edge;

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // timer clock and trigger pin
    // ------------------------------------------------------------------
    ptc_prescaler u_prescaler (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .div      (st.tick_div),
        .tick     (tick)
    );

    ptc_edge_sync u_trigger (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .pin        (external_trigger_pin),
        .fall_sel   (st.trig_fall),
        .edge_pulse (trig_edge)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic             bus_req;
    logic             wr_ok;
    logic             rd_ok;
    logic             single_pulse;
    logic             run_rise;
    logic             hit_a;
    logic             hit_p;
    logic             hit_ovf;
    logic             set_a;
    logic             set_p;
    logic             do_clear;
    logic             pwm_active;
    logic             wave;
    logic             sw_run;
    logic [CNT_W-1:0] pwm_last;
    logic [31:0]      rd_word;

    always_comb begin
        next_st = st;

        // bus handshake: answer one cycle after the request is seen
        bus_req         = (avs_read || avs_write) && st.waitreq;
        wr_ok           = avs_write && !st.waitreq && avs_byteenable[0];
        rd_ok           = avs_read && st.waitreq;
        next_st.waitreq = !bus_req;

        // read decode; narrow registers sit in the low bits
        rd_word = 32'h0000_0000;
        unique case (avs_address)
            OFS_CONTROL: begin
                rd_word[CTL_RUN]       = st.run_bit;
                rd_word[CTL_INIT_LVL]  = st.out_initial_level;
                rd_word[CTL_INVERT]    = st.out_invert;
                rd_word[CTL_CLR_SRC]   = st.clear_source_sel;
                rd_word[CTL_ACT_HI:CTL_ACT_LO]   = st.action;
                rd_word[CTL_MODE_HI:CTL_MODE_LO] = st.mode;
                rd_word[CTL_TRIG_FALL] = st.trig_fall;
            end
            OFS_STATUS: begin
                rd_word[STS_MATCH_A] = st.match_a_flag;
                rd_word[STS_MATCH_P] = st.match_p_flag;
            end
            OFS_CMP_A_LOW:   rd_word[7:0] = st.compare_a_value[7:0];       // [R18]
            OFS_CMP_A_HIGH:  rd_word[1:0] = st.compare_a_value[9:8];       // [R18]
            OFS_PERIOD_LOW:  rd_word[7:0] = st.period_value[7:0];          // [R19]
            OFS_PERIOD_HIGH: rd_word[1:0] = st.period_value[9:8];          // [R19]
            OFS_COUNT_LOW:   rd_word[7:0] = st.count[7:0];                 // [R21]
            OFS_COUNT_HIGH:  rd_word[1:0] = st.count[9:8];                 // [R21]
            OFS_TICK_DIV:    rd_word[7:0] = st.tick_div;
            default:         rd_word = 32'h0000_0000;
        endcase
        if (rd_ok) begin
            next_st.rdata = rd_word;
        end

        // register writes take effect at the edge where waitrequest is low
        sw_run = st.run_bit;
        if (wr_ok) begin
            unique case (avs_address)
                OFS_CONTROL: begin
                    sw_run                    = avs_writedata[CTL_RUN];
                    next_st.out_initial_level = avs_writedata[CTL_INIT_LVL];
                    next_st.out_invert        = avs_writedata[CTL_INVERT];
                    next_st.clear_source_sel  = avs_writedata[CTL_CLR_SRC];
                    next_st.action = ptc_action_t'(avs_writedata[CTL_ACT_HI:CTL_ACT_LO]);
                    next_st.mode   = ptc_mode_t'(avs_writedata[CTL_MODE_HI:CTL_MODE_LO]);
                    next_st.trig_fall         = avs_writedata[CTL_TRIG_FALL];
                end
                OFS_CMP_A_LOW:   next_st.compare_a_value[7:0] = avs_writedata[7:0];  // [R18]
                OFS_CMP_A_HIGH:  next_st.compare_a_value[9:8] = avs_writedata[1:0];  // [R18]
                OFS_PERIOD_LOW:  next_st.period_value[7:0]    = avs_writedata[7:0];  // [R19]
                OFS_PERIOD_HIGH: next_st.period_value[9:8]    = avs_writedata[1:0];  // [R19]
                OFS_TICK_DIV:    next_st.tick_div             = avs_writedata[7:0];
                default: begin
                end
            endcase
        end

        // mode decode
        single_pulse = (st.mode == PTC_MODE_PWM) && (st.action == PTC_ACT_TOGGLE);  // [R01] [R14]
        run_rise     = st.run_bit && !st.run_prev;
        next_st.run_prev = st.run_bit;

        // comparators look at the value the counter holds on this tick
        pwm_last = st.period_value - 10'h001;   // zero period wraps to 1024 counts
        hit_a    = 1'b0;
        hit_p    = 1'b0;
        hit_ovf  = 1'b0;
        set_a    = 1'b0;
        set_p    = 1'b0;
        do_clear = 1'b0;

        unique case (st.mode)
            PTC_MODE_PWM: begin
                if (single_pulse) begin
                    hit_a = (st.count == st.compare_a_value);              // [R16]
                    set_a = hit_a;                                         // [R16]
                end else begin
                    hit_a    = (st.count == st.compare_a_value);
                    hit_p    = (st.count == pwm_last);                     // [R09]
                    set_a    = hit_a;                                      // [R11]
                    set_p    = hit_p;                                      // [R11]
                    do_clear = hit_p;                                      // [R09]
                end
            end
            PTC_MODE_CAPTURE: begin
                // capture is not built here; the counter runs free to 3FF
                hit_ovf  = (st.count == CNT_MAX);
                do_clear = hit_ovf;
            end
            default: begin
                // compare and timer modes share one counting scheme     [R08]
                if (st.clear_source_sel) begin
                    hit_a    = (st.compare_a_value != CNT_RESET)
                               && (st.count == st.compare_a_value);        // [R03] [R04]
                    hit_ovf  = (st.compare_a_value == CNT_RESET)
                               && (st.count == CNT_MAX);                   // [R04]
                    set_a    = hit_a;                                      // [R03]
                    do_clear = hit_a || hit_ovf;                           // [R03]
                end else begin
                    hit_a    = (st.compare_a_value != CNT_RESET)
                               && (st.count == st.compare_a_value);        // [R04]
                    hit_p    = (st.period_value != CNT_RESET)
                               && (st.count == st.period_value);           // [R02]
                    hit_ovf  = (st.period_value == CNT_RESET)
                               && (st.count == CNT_MAX);                   // [R02]
                    set_a    = hit_a;                                      // [R02]
                    set_p    = hit_p;                                      // [R02]
                    do_clear = hit_p || hit_ovf;                           // [R02]
                end
            end
        endcase

        // counter: steps only on a tick while running
        if (single_pulse && run_rise) begin
            next_st.count = CNT_RESET;                                     // [R17]
        end else if (st.run_bit && tick) begin
            if (do_clear) begin
                next_st.count = CNT_RESET;
            end else begin
                next_st.count = st.count + 10'h001;                        // [R22]
            end
        end

        // matches only count on a tick of a running counter
        set_a = set_a && st.run_bit && tick && !run_rise;
        set_p = set_p && st.run_bit && tick && !run_rise;

        // sticky flags: a new match wins over a software clear
        if (wr_ok && (avs_address == OFS_STATUS)) begin
            if (avs_writedata[STS_MATCH_A]) begin
                next_st.match_a_flag = 1'b0;                               // [R23]
            end
            if (avs_writedata[STS_MATCH_P]) begin
                next_st.match_p_flag = 1'b0;                               // [R23]
            end
        end
        if (set_a) begin
            next_st.match_a_flag = 1'b1;                                   // [R23]
        end
        if (set_p) begin
            next_st.match_p_flag = 1'b1;                                   // [R23]
        end

        // run bit: software write, then match stop, then trigger start
        next_st.run_bit = sw_run;
        if (single_pulse && set_a) begin
            next_st.run_bit = 1'b0;                                        // [R16]
        end
        if (single_pulse && trig_edge) begin
            next_st.run_bit = 1'b1;                                        // [R15]
        end

        // compare-mode pin level: preset on run rise, then act on A flag
        if (run_rise) begin
            next_st.cmp_level = st.out_initial_level;                      // [R07]
        end else if (set_a && (st.mode == PTC_MODE_COMPARE)) begin         // [R05]
            unique case (st.action)
                PTC_ACT_NONE:   next_st.cmp_level = st.cmp_level;          // [R06]
                PTC_ACT_LOW:    next_st.cmp_level = 1'b0;                  // [R06]
                PTC_ACT_HIGH:   next_st.cmp_level = 1'b1;                  // [R06]
                PTC_ACT_TOGGLE: next_st.cmp_level = !st.cmp_level;         // [R06]
            endcase
        end

        // PWM duty: a duty at or above the period holds the active level
        pwm_active = (st.count < st.compare_a_value)
                     || ((st.period_value != CNT_RESET)
                         && (st.compare_a_value >= st.period_value));      // [R09] [R10]

        // output waveform; initial level is the active level in PWM
        unique case (st.action)
            PTC_ACT_NONE: wave = !st.out_initial_level;                    // [R12] [R13]
            PTC_ACT_LOW:  wave = st.out_initial_level;                     // [R12] [R13]
            PTC_ACT_HIGH: wave = pwm_active ? st.out_initial_level
                                            : !st.out_initial_level;       // [R12]
            PTC_ACT_TOGGLE: begin
                // pulse is active while run stays high
                wave = st.run_bit ? st.out_initial_level
                                  : !st.out_initial_level;                 // [R15] [R16]
            end
        endcase

        // pin drive
        unique case (st.mode)
            PTC_MODE_COMPARE: begin
                next_st.timer_out    = st.cmp_level ^ st.out_invert;       // [R20]
                next_st.timer_out_en = 1'b1;
            end
            PTC_MODE_PWM: begin
                next_st.timer_out    = wave ^ st.out_invert;               // [R12] [R20]
                next_st.timer_out_en = 1'b1;
            end
            default: begin
                // pin released for other uses; invert has no effect here
                next_st.timer_out    = 1'b0;                               // [R08] [R20]
                next_st.timer_out_en = 1'b0;                               // [R08]
            end
        endcase
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st         <= '0;
            st.waitreq <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign avs_readdata    = st.rdata;
    assign avs_waitrequest = st.waitreq;
    assign timer_out       = st.timer_out;
    assign timer_out_en    = st.timer_out_en;

endmodule : ptc_timer

// *** sim/ptc_load.sv ***
// ptc_load: trigger source on the far side of the timer
`timescale 1ns/1ps
module ptc_load (
    input  wire logic core_clk,
    input  wire logic fire,
    output logic      external_trigger_pin = 1'b0
);
    logic [2:0] hold = 3'h0;
    // held several clocks so the three-flop synchroniser cannot miss it
    always @(posedge core_clk) begin
        hold <= fire ? 3'h5 : hold - 3'(hold != 3'h0);
        external_trigger_pin <= hold != 3'h0;
    end
endmodule : ptc_load

// *** sim/ptc_timer_sva.sv ***
// ptc_timer_sva: bus handshake and pin assertions on the timer ports
`timescale 1ns/1ps
module ptc_timer_sva
    import ptc_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              rst_b,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic              timer_out,
    input wire logic              timer_out_en
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wait_one_a:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered");
    wait_rel_a:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer too long");
    wait_cause_a:
    assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
        else $error("answer without request");
    rd_hold_a:
    assert property (!(avs_read && !avs_waitrequest) |-> $stable(avs_readdata))
        else $error("read data moved");
    cmpa_hi_a:
    assert property (avs_read && !avs_waitrequest && avs_address == OFS_CMP_A_HIGH
        |-> avs_readdata[31:2] == 30'h0) else $error("compare high bits");
    per_hi_a:
    assert property (avs_read && !avs_waitrequest && avs_address == OFS_PERIOD_HIGH
        |-> avs_readdata[31:2] == 30'h0) else $error("period high bits");
    cnt_hi_a:
    assert property (avs_read && !avs_waitrequest && avs_address == OFS_COUNT_HIGH
        |-> avs_readdata[31:2] == 30'h0) else $error("count high bits");
    pin_off_a:
    assert property (!timer_out_en |-> !timer_out) else $error("pin driven while off");
endmodule : ptc_timer_sva

bind ptc_timer ptc_timer_sva u_sva (.core_clk, .rst_b, .avs_address, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .timer_out, .timer_out_en);

// *** sim/tb_top.sv ***
// tb_top: self-checking bench for the periodic timer
`timescale 1ns/1ps
module tb_top
    import ptc_pkg::*;
;
    logic              core_clk, rst_b, avs_read, avs_write, avs_waitrequest, fire;
    logic              external_trigger_pin, timer_out, timer_out_en;
    logic [ADDR_W-1:0] avs_address;
    logic [31:0]       avs_writedata, avs_readdata, seed, exp_q[$];
    logic [3:0]        avs_byteenable, m;
    int                n_checks, n_mismatch, k;
    ptc_timer dut (.core_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .external_trigger_pin,
        .timer_out, .timer_out_en);
    ptc_load u_load (.core_clk, .fire, .external_trigger_pin);
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [5:0] a, input logic [8:0] d, input logic be);
        @(posedge core_clk);
        avs_address    <= a;
        avs_writedata  <= {23'h0, d};
        avs_byteenable <= {3'h0, be};
        avs_read       <= !w;
        avs_write      <= w;
        // iff sees waitrequest as it stood before this edge
        @(posedge core_clk iff !avs_waitrequest);
        avs_read       <= 1'b0;
        avs_write      <= 1'b0;
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [8:0] d);
        bus(1'b1, a, d, 1'b1);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 9'h0, 1'b1);
    endtask : rd
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    always @(posedge core_clk) begin
        if (avs_read && !avs_waitrequest) begin
            chk(avs_readdata, exp_q.pop_front());
        end
    end
    initial begin
        cyc(20000);
        n_mismatch++;
        stop_test();
    end
    initial begin
        {rst_b, avs_read, avs_write, fire, avs_address, avs_writedata, avs_byteenable} = '0;
        seed = 32'h2BD4;
        cyc(2);
        rst_b <= 1'b1;
        cyc(3);
        rd(OFS_PERIOD_LOW, 0);
        rd(OFS_COUNT_HIGH, 0);
        seed = lfsr(seed);
        wr(OFS_CMP_A_HIGH, seed[8:0]);
        rd(OFS_CMP_A_HIGH, seed[1:0]);
        wr(OFS_PERIOD_HIGH, seed[16:8]);
        rd(OFS_PERIOD_HIGH, seed[9:8]);
        wr(OFS_TICK_DIV, seed[8:0]);
        rd(OFS_TICK_DIV, seed[7:0]);
        wr(OFS_TICK_DIV, 9'h0);
        bus(1'b1, OFS_CMP_A_LOW, 9'hFF, 1'b0);
        rd(OFS_CMP_A_LOW, 0);
        rd(6'h3C, 0);
        wr(OFS_CMP_A_HIGH, 9'h0);
        wr(OFS_PERIOD_HIGH, 9'h0);
        $display("test registers done");
        wr(OFS_PERIOD_LOW, 9'h3);
        wr(OFS_CMP_A_LOW, 9'h2);
        wr(OFS_CONTROL, 9'h21);
        cyc(20);
        chk(timer_out, 1'b1);
        rd(OFS_STATUS, 3);
        wr(OFS_CMP_A_LOW, 9'h40);
        for (k = 0; k < 3; k++) begin
            wr(OFS_CONTROL, 9'(k * 16 + 10));
            wr(OFS_STATUS, 9'h3);
            wr(OFS_CONTROL, 9'(k * 16 + 11));
            // preset lands one clock after run rises, pin one clock later
            cyc(3);
            chk(timer_out, 1'b1);
            cyc(80);
            chk(timer_out, k != 1);
            rd(OFS_STATUS, 1);
        end
        $display("test compare done");
        wr(OFS_PERIOD_LOW, 9'h4);
        wr(OFS_CMP_A_LOW, 9'h2);
        wr(OFS_CONTROL, 9'h83);
        wr(OFS_STATUS, 9'h3);
        // count may sit above the new period and has to wrap past 3FF first
        cyc(1100);
        chk(timer_out, 1'b0);
        rd(OFS_STATUS, 3);
        wr(OFS_CONTROL, 9'h97);
        cyc(3);
        chk(timer_out, 1'b0);
        for (k = 0; k < 2; k++) begin
            wr(OFS_CMP_A_LOW, k ? 9'h5 : 9'h2);
            wr(OFS_CONTROL, 9'hA3);
            cyc(1); // first edge still shows the old setting
            m = 4'h0;
            repeat (8) begin
                @(posedge core_clk);
                m += timer_out;
            end
            chk(m, k ? 8 : 4);
        end
        wr(OFS_CONTROL, 9'hC5);
        cyc(3);
        chk(timer_out_en, 1'b0);
        $display("test pwm done");
        wr(OFS_CMP_A_LOW, 9'h14);
        wr(OFS_CONTROL, 9'hB2);
        wr(OFS_STATUS, 9'h3);
        fire <= 1'b1;
        cyc(1);
        fire <= 1'b0;
        cyc(10);
        chk(timer_out, 1'b1);
        cyc(30);
        chk(timer_out, 1'b0);
        rd(OFS_CONTROL, 9'hB2);
        rd(OFS_STATUS, 1);
        wr(OFS_CONTROL, 9'hB3);
        cyc(10);
        chk(timer_out, 1'b1);
        cyc(30);
        chk(timer_out, 1'b0);
        $display("test pulse done");
        cyc(5);
        stop_test();
    end
endmodule : tb_top
